// File: inc/vcs_cfg.svh
// Purpose: Constants for the video capture and storage block
// Assumes: Included by the package and the design file
// Notes: Widths, fills, masks and limits defined here; the bench repeats masks and fills and sets its own smaller limits
`ifndef VCS_CFG_SVH
`define VCS_CFG_SVH
`define VCS_WORD_W 64
`define VCS_ADDR_W 32
`define VCS_PIX_W 12
`define VCS_HPOS_W 12
`define VCS_LINE_W 11
`define VCS_BYTE_W 8
`define VCS_WORD_BYTES 32'h0000_0008
`define VCS_SLOTS8 4'h8
`define VCS_SLOTS16 4'h4
`define VCS_MAX_HPIX 2048
`define VCS_MAX_VLINE 1536
`define VCS_FIFO_AW 2
`define VCS_FILL_LUMA 8'h10
`define VCS_FILL_CHROMA 8'h80
`define VCS_MASK10 16'h03FF
`define VCS_MASK12 16'h0FFF
`define VCS_STUFF10 64'hFC00_FC00_FC00_FC00
`define VCS_STUFF12 64'hF000_F000_F000_F000
`endif

// File: inc/vcs_pkg.sv
// Purpose: Types shared by the video capture and storage block
// Assumes: vcs_cfg.svh supplies the widths
// Notes: Region index is {field, horizontal blanking}
`include "vcs_cfg.svh"
package vcs_pkg;
	typedef enum logic [1:0] {
		VCS_PIX8 = 2'b00,
		VCS_PIX10 = 2'b01,
		VCS_PIX12 = 2'b10
	} vcs_pix_e;
	typedef enum logic [1:0] {
		VCS_KIND_IMAGE = 2'b00,
		VCS_KIND_HANC = 2'b01,
		VCS_KIND_VANC = 2'b10
	} vcs_kind_e;
	typedef struct packed {
		logic capture_en;
		logic raw_mode;
		logic interlaced;
		logic frame_layout;
		logic hval_inv;
		logic vval_inv;
		logic fid_inv;
		vcs_pix_e pix_width;
		logic [`VCS_LINE_W-1:0] line_event_count;
	} vcs_cap_ctrl_s;
	typedef struct packed {
		logic display_en;
		logic anc_en;
	} vcs_disp_ctrl_s;
	typedef struct packed {
		logic [`VCS_HPOS_W-1:0] hstart;
		logic [`VCS_HPOS_W-1:0] hsize;
		logic [`VCS_LINE_W-1:0] vstart;
		logic [`VCS_LINE_W-1:0] vsize;
	} vcs_region_s;
	typedef struct packed {
		vcs_cap_ctrl_s cap;
		vcs_disp_ctrl_s disp;
		vcs_region_s [3:0] region;
	} vcs_link_cfg_s;
	typedef struct packed {
		logic [`VCS_WORD_W-1:0] data;
		logic sof;
		logic sol;
		logic field;
		vcs_kind_e kind;
	} vcs_word_s;
endpackage

// File: design/vcs_top.sv
// Purpose: Video line storage, ancillary output filler and raw capture
// Assumes: Pins and the blanking output run on link_clk
// Notes: Config crosses by handshake, words by a gray-pointer FIFO
//
// Behaviour
// - Field layout: one start, step one offset
// - Frame layout: bottom plus offset, step doubled
// - Field/frame bits ignored for progressive raster
// - Only payload fetched; filler made internally
// - Separate ancillary regions per field and kind
// - Ancillary lines counted from vsync fall
// - Any ancillary size within area accepted
// - All blanking data stored, no subregion
// - Vertical ancillary step uses image offset
// - Ancillary in active lines treated as image
// - Raw capture stores valid samples only
// - Raw widths 8, 10, 12 bits
// - Raw frames up to 2048 by 1536
// - Raw samples byte aligned, never packed
// - Valid and field polarities selectable
// - Raw supports separated or interleaved fields
// - Line and frame events in raw only
// - Raw stored in raster order only
// - Raw link-side config applied at vertical valid fall; layout, source select live
// - Valid falls are syncs; both valid needed
// - Field ident sampled at vertical valid rise
// - Blanking filler 10h luma, 80h chroma
// - Wide samples in zeroed 16-bit slots
`timescale 1ns/1ps
`include "vcs_cfg.svh"
module vcs_top import vcs_pkg::*; #(
	parameter int MAX_HPIX = `VCS_MAX_HPIX,
	parameter int MAX_VLINE = `VCS_MAX_VLINE
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire vcs_cap_ctrl_s capture_channel_control,
	input wire vcs_disp_ctrl_s display_channel_control,
	input wire vcs_region_s [3:0] anc_region,
	input wire logic [`VCS_ADDR_W-1:0] top_start_addr,
	input wire logic [`VCS_ADDR_W-1:0] hanc_start_addr,
	input wire logic [`VCS_ADDR_W-1:0] vanc_start_addr,
	input wire logic [`VCS_ADDR_W-1:0] image_line_offset_reg,
	input wire logic [`VCS_ADDR_W-1:0] hanc_line_offset,
	input wire logic h_valid_in,
	input wire logic v_valid_in,
	input wire logic field_ident_in,
	input wire logic [`VCS_PIX_W-1:0] raw_pixel_in,
	input wire logic yc_wr_valid,
	output logic yc_wr_ready,
	input wire vcs_word_s yc_wr,
	output logic mem_wr_valid,
	input wire logic mem_wr_ready,
	output logic [`VCS_ADDR_W-1:0] mem_wr_addr,
	output logic [`VCS_WORD_W-1:0] mem_wr_data,
	output logic line_event,
	output logic frame_event,
	input wire logic tx_vsync_in,
	input wire logic [`VCS_HPOS_W-1:0] tx_hpos,
	input wire logic tx_in_hblank,
	input wire logic tx_field,
	input wire logic tx_active_line,
	input wire logic [`VCS_BYTE_W-1:0] tx_image_byte,
	input wire logic [`VCS_BYTE_W-1:0] tx_anc_byte,
	output logic tx_anc_take,
	output logic [`VCS_BYTE_W-1:0] tx_byte
);
	localparam int AW = `VCS_FIFO_AW;
	localparam int DEPTH = 1 << AW;

	// ------------------------------------------------------------
	// Link reset and configuration crossing
	// ------------------------------------------------------------
	logic lrst_s1, link_rst;
	vcs_link_cfg_s cfg_now, cfg_shadow, pend;
	vcs_cap_ctrl_s act_cap;
	vcs_disp_ctrl_s act_disp;
	vcs_region_s [3:0] act_region;
	logic cfg_req, ack_s1, ack_s2, req_s1, req_s2, cfg_ack;

	always_ff @(posedge link_clk) begin
		lrst_s1 <= sys_rst;
		link_rst <= lrst_s1;
	end

	assign cfg_now = {capture_channel_control, display_channel_control,
		anc_region};

	// Shadow holds still until the link side has copied it
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
			cfg_req <= 1'b0;
			cfg_shadow <= '0;
		end else begin
			ack_s1 <= cfg_ack;
			ack_s2 <= ack_s1;
			if (cfg_req == ack_s2 && cfg_now != cfg_shadow) begin
				cfg_shadow <= cfg_now;
				cfg_req <= ~cfg_req;
			end
		end
	end

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			cfg_ack <= 1'b0;
			pend <= '0;
		end else begin
			req_s1 <= cfg_req;
			req_s2 <= req_s1;
			if (req_s2 != cfg_ack) begin
				pend <= cfg_shadow;
				cfg_ack <= req_s2;
			end
		end
	end

	// ------------------------------------------------------------
	// Raw pin stage
	// ------------------------------------------------------------
	logic hv_q, vv_q, fid_q, hv_d, vv_d;
	logic [`VCS_PIX_W-1:0] pix_q;
	logic vv_rise, vv_fall, hv_fall;

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			hv_q <= 1'b0;
			vv_q <= 1'b0;
			fid_q <= 1'b0;
			hv_d <= 1'b0;
			vv_d <= 1'b0;
			pix_q <= '0;
		end else begin
			hv_q <= h_valid_in ^ act_cap.hval_inv;
			vv_q <= v_valid_in ^ act_cap.vval_inv;
			fid_q <= field_ident_in ^ act_cap.fid_inv;
			hv_d <= hv_q;
			vv_d <= vv_q;
			pix_q <= raw_pixel_in;
		end
	end

	assign vv_rise = vv_q & ~vv_d;
	assign vv_fall = ~vv_q & vv_d;
	assign hv_fall = ~hv_q & hv_d;

	// New raw settings land only at vertical valid fall
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			act_cap <= '0;
		end else if (vv_fall) begin
			act_cap <= pend.cap;
		end
	end

	// ------------------------------------------------------------
	// Raw capture and packing
	// ------------------------------------------------------------
	logic armed, field_cur, sof_pend, sol_pend;
	logic [3:0] slot, nslots;
	logic [11:0] pix_cnt;
	logic [`VCS_LINE_W-1:0] vline, lev_cnt;
	logic [`VCS_WORD_W-1:0] acc, next_acc;
	logic [15:0] pix_mask;
	logic cap_ok, push, fifo_full, line_tog, frame_tog;
	vcs_word_s push_word;

	assign nslots = (act_cap.pix_width == VCS_PIX8) ? `VCS_SLOTS8 :
		`VCS_SLOTS16;
	assign pix_mask = (act_cap.pix_width == VCS_PIX10) ? `VCS_MASK10 :
		`VCS_MASK12;
	// Only samples inside both valids are kept
	assign cap_ok = armed && hv_q && vv_q &&
		(32'(pix_cnt) < MAX_HPIX) && (32'(vline) < MAX_VLINE);

	// Byte-aligned slots, pixel 0 lowest, zero stuffing
	always_comb begin
		next_acc = acc;
		if (cap_ok) begin
			if (act_cap.pix_width == VCS_PIX8) begin
				next_acc[slot[2:0]*8 +: 8] = pix_q[7:0];
			end else begin
				next_acc[slot[1:0]*16 +: 16] = {4'h0, pix_q} & pix_mask;
			end
		end
	end

	assign push = (cap_ok && slot == nslots - 4'h1) ||
		(hv_fall && slot != 4'h0);
	assign push_word = '{data: next_acc, sof: sof_pend,
		sol: sol_pend | sof_pend, field: field_cur, kind: VCS_KIND_IMAGE};

	// Words leave in raster order, line by line
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			acc <= '0;
			slot <= 4'h0;
			pix_cnt <= '0;
		end else if (push || hv_fall) begin
			acc <= '0;
			slot <= 4'h0;
			pix_cnt <= hv_fall ? 12'h000 : pix_cnt + 12'h001;
		end else if (cap_ok) begin
			acc <= next_acc;
			slot <= slot + 4'h1;
			pix_cnt <= pix_cnt + 12'h001;
		end
	end

	// Field tag follows field ident caught at valid rise when interlaced, zero when progressive
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			armed <= 1'b0;
			field_cur <= 1'b0;
			sof_pend <= 1'b0;
			sol_pend <= 1'b0;
			vline <= '0;
		end else begin
			if (vv_fall) begin
				armed <= pend.cap.capture_en & pend.cap.raw_mode;
			end
			if (vv_rise) begin
				field_cur <= act_cap.interlaced ? fid_q : 1'b0;
				sof_pend <= 1'b1;
				vline <= '0;
			end else if (push) begin
				sof_pend <= 1'b0;
			end
			if (hv_fall) begin
				sol_pend <= 1'b1;
				if (armed && vv_q) begin
					vline <= vline + 11'h001;
				end
			end else if (push) begin
				sol_pend <= 1'b0;
			end
		end
	end

	// Line event every programmed count, frame event at area end
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			lev_cnt <= '0;
			line_tog <= 1'b0;
			frame_tog <= 1'b0;
		end else begin
			if (vv_rise) begin
				lev_cnt <= '0;
			end else if (hv_fall && armed && vv_q &&
				act_cap.line_event_count != '0) begin
				if (lev_cnt == act_cap.line_event_count - 11'h001) begin
					lev_cnt <= '0;
					line_tog <= ~line_tog;
				end else begin
					lev_cnt <= lev_cnt + 11'h001;
				end
			end
			if (vv_fall && armed) begin
				frame_tog <= ~frame_tog;
			end
		end
	end

	// ------------------------------------------------------------
	// Word crossing FIFO
	// ------------------------------------------------------------
	// No stall exists toward a sensor: a full FIFO drops the word
	vcs_word_s fifo_mem [0:DEPTH-1];
	logic [AW:0] wbin, wgray, rbin, rgray, rg_s1, rg_s2, wg_s1, wg_s2;
	logic [AW:0] wbin_n, rbin_n;
	logic fifo_empty, pop;

	assign wbin_n = wbin + 1'b1;
	assign rbin_n = rbin + 1'b1;
	assign fifo_full = (wgray == {~rg_s2[AW:AW-1], rg_s2[AW-2:0]});
	assign fifo_empty = (rgray == wg_s2);

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			wbin <= '0;
			wgray <= '0;
			rg_s1 <= '0;
			rg_s2 <= '0;
		end else begin
			rg_s1 <= rgray;
			rg_s2 <= rg_s1;
			if (push && !fifo_full) begin
				fifo_mem[wbin[AW-1:0]] <= push_word;
				wbin <= wbin_n;
				wgray <= wbin_n ^ (wbin_n >> 1);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rbin <= '0;
			rgray <= '0;
			wg_s1 <= '0;
			wg_s2 <= '0;
		end else begin
			wg_s1 <= wgray;
			wg_s2 <= wg_s1;
			if (pop) begin
				rbin <= rbin_n;
				rgray <= rbin_n ^ (rbin_n >> 1);
			end
		end
	end

	// ------------------------------------------------------------
	// Event crossing
	// ------------------------------------------------------------
	logic [2:0] ls, fs;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ls <= '0;
			fs <= '0;
			line_event <= 1'b0;
			frame_event <= 1'b0;
		end else begin
			ls <= {ls[1:0], line_tog};
			fs <= {fs[1:0], frame_tog};
			line_event <= ls[1] ^ ls[2];
			frame_event <= fs[1] ^ fs[2];
		end
	end

	// ------------------------------------------------------------
	// Memory address generation
	// ------------------------------------------------------------
	vcs_word_s src;
	logic raw_sel, src_valid, load, take, frame_mode;
	logic [`VCS_ADDR_W-1:0] ofst, step, base, field_base, next_addr;
	logic [`VCS_ADDR_W-1:0] cur_addr;
	logic [`VCS_ADDR_W-1:0] line_addr [0:2];

	assign raw_sel = capture_channel_control.raw_mode;
	assign src_valid = raw_sel ? !fifo_empty : yc_wr_valid;
	assign src = raw_sel ? fifo_mem[rbin[AW-1:0]] : yc_wr;
	assign load = !mem_wr_valid || mem_wr_ready;
	assign take = src_valid && load;
	assign pop = raw_sel && take;
	assign yc_wr_ready = !raw_sel && load;

	// Vertical ancillary shares the image offset
	assign ofst = (src.kind == VCS_KIND_HANC) ? hanc_line_offset :
		image_line_offset_reg;
	// Every blanking word is stored, no region filter applies
	always_comb begin
		unique case (src.kind)
			VCS_KIND_HANC: base = hanc_start_addr;
			VCS_KIND_VANC: base = vanc_start_addr;
			default: base = top_start_addr;
		endcase
	end

	// Progressive raster ignores the layout bit
	assign frame_mode = capture_channel_control.interlaced &&
		capture_channel_control.frame_layout;
	// Field layout shares one start; frame interleaves lines
	assign step = frame_mode ? {ofst[`VCS_ADDR_W-2:0], 1'b0} : ofst;
	assign field_base = (frame_mode && src.field) ? base + ofst : base;

	always_comb begin
		if (src.sof) begin
			next_addr = field_base;
		end else if (src.sol) begin
			next_addr = line_addr[src.kind] + step;
		end else begin
			next_addr = cur_addr + `VCS_WORD_BYTES;
		end
	end

	// Ancillary on active lines arrives tagged as image
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mem_wr_valid <= 1'b0;
			mem_wr_addr <= '0;
			mem_wr_data <= '0;
			cur_addr <= '0;
			for (int k = 0; k < 3; k++) begin
				line_addr[k] <= '0;
			end
		end else if (load) begin
			mem_wr_valid <= src_valid;
			if (take) begin
				mem_wr_addr <= next_addr;
				mem_wr_data <= src.data;
				cur_addr <= next_addr;
				if (src.sof || src.sol) begin
					line_addr[src.kind] <= next_addr;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Blanking output filler
	// ------------------------------------------------------------
	logic txv_d, tx_vfall, in_h, in_v;
	logic [`VCS_LINE_W-1:0] vcount;
	vcs_region_s rg;

	assign tx_vfall = ~tx_vsync_in & txv_d;

	// Line zero is the line where vsync falls
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			txv_d <= 1'b0;
			vcount <= '0;
			act_disp <= '0;
			act_region <= '0;
		end else begin
			txv_d <= tx_vsync_in;
			if (tx_vfall) begin
				vcount <= '0;
				act_disp <= pend.disp;
				act_region <= pend.region;
			end else if (tx_hpos == '0) begin
				vcount <= vcount + 11'h001;
			end
		end
	end

	// Region chosen by field and blanking kind
	assign rg = act_region[{tx_field, tx_in_hblank}];
	// Start taken as aligned, any size accepted
	assign in_h = (tx_hpos >= rg.hstart) && (tx_hpos - rg.hstart < rg.hsize);
	assign in_v = (vcount >= rg.vstart) && (vcount - rg.vstart < rg.vsize);
	assign tx_anc_take = act_disp.display_en && act_disp.anc_en &&
		!tx_active_line && in_h && in_v;

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			tx_byte <= `VCS_FILL_CHROMA;
		end else if (tx_active_line) begin
			tx_byte <= tx_image_byte;
		end else if (tx_anc_take) begin
			tx_byte <= tx_anc_byte;
		end else begin
			tx_byte <= tx_hpos[0] ? `VCS_FILL_LUMA : `VCS_FILL_CHROMA;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [`VCS_ADDR_W-1:0] chk_prev_line;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			chk_prev_line <= '0;
		end else if (take && src.kind == VCS_KIND_IMAGE &&
			(src.sof || src.sol)) begin
			chk_prev_line <= next_addr;
		end
	end

	chk_luma_fill: assert property (
		@(posedge link_clk) disable iff (link_rst)
		(!tx_active_line && !tx_anc_take && tx_hpos[0])
		|=> tx_byte == `VCS_FILL_LUMA) else $error("luma filler wrong");
	chk_chroma_fill: assert property (
		@(posedge link_clk) disable iff (link_rst)
		(!tx_active_line && !tx_anc_take && !tx_hpos[0])
		|=> tx_byte == `VCS_FILL_CHROMA) else $error("chroma filler wrong");
	chk_active_as_image: assert property (
		@(posedge link_clk) disable iff (link_rst)
		tx_active_line |=> !$past(tx_anc_take) &&
		tx_byte == $past(tx_image_byte)) else $error("active line not image");
	chk_field_shared_base: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(take && src.sof && src.kind == VCS_KIND_IMAGE && !frame_mode)
		|=> mem_wr_addr == $past(top_start_addr)) else $error("field base");
	chk_frame_bottom_base: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(take && src.sof && src.field && src.kind == VCS_KIND_IMAGE &&
		frame_mode)
		|=> mem_wr_addr ==
		$past(top_start_addr) + $past(image_line_offset_reg))
		else $error("bottom field base");
	chk_line_step: assert property (
		@(posedge core_clk) disable iff (sys_rst)
		(take && src.sol && !src.sof && src.kind == VCS_KIND_IMAGE)
		|=> mem_wr_addr == $past(chk_prev_line) + $past(step))
		else $error("line step wrong");
	chk_blank_dropped: assert property (
		@(posedge link_clk) disable iff (link_rst)
		!(hv_q && vv_q) |=> $stable(pix_cnt) || pix_cnt == '0)
		else $error("blank sample counted");
	chk_zero_stuff: assert property (
		@(posedge link_clk) disable iff (link_rst)
		(push && act_cap.pix_width == VCS_PIX12)
		|-> (push_word.data & `VCS_STUFF12) == '0) else $error("stuffing");
	chk_cfg_at_vfall: assert property (
		@(posedge link_clk) disable iff (link_rst)
		!$stable(act_cap) |-> $past(vv_fall)) else $error("config early");
	chk_field_sample: assert property (
		@(posedge link_clk) disable iff (link_rst)
		(vv_rise && act_cap.interlaced) |=> field_cur == $past(fid_q))
		else $error("field ident sample");

	cov_frame_event: cover property (@(posedge core_clk) disable iff (sys_rst)
		frame_event);
	cov_line_event: cover property (@(posedge core_clk) disable iff (sys_rst)
		line_event);
	cov_anc_take: cover property (@(posedge link_clk) disable iff (link_rst)
		tx_anc_take ##1 !tx_anc_take);
	cov_bottom_frame: cover property (@(posedge core_clk) disable iff (sys_rst)
		take && src.sof && src.field && frame_mode);
endmodule

// File: testbench/vcs_sensor_model.sv
// Purpose: Raw sensor front end model for the capture pins
// Assumes: One frame is sent each time req differs from ack
// Notes: Pixel bus keeps toggling while invalid, so stale data shows
`timescale 1ns/1ps
module vcs_sensor_model (
	input wire logic link_clk,
	input wire logic req,
	input wire logic [4:0] n_pix,
	input wire logic [3:0] n_lines,
	input wire logic fid,
	input wire logic [2:0] inv,
	output logic h_valid_in,
	output logic v_valid_in,
	output logic field_ident_in,
	output logic [11:0] raw_pixel_in,
	output logic ack
);
	logic hv;
	logic vv;
	logic fd;
	// --------
	// Pins
	// --------
	assign h_valid_in = hv ^ inv[0];
	assign v_valid_in = vv ^ inv[1];
	assign field_ident_in = fd ^ inv[2];
	task automatic step(input logic h, input logic v, input logic [11:0] p);
		@(posedge link_clk);
		hv <= h;
		vv <= v;
		raw_pixel_in <= h ? p : ~raw_pixel_in;
	endtask
	initial begin
		hv = 1'b0;
		vv = 1'b0;
		fd = 1'b0;
		ack = 1'b0;
		raw_pixel_in = 12'h000;
		forever begin
			@(posedge link_clk);
			if (req !== ack) begin
				// Field set well before the frame opens
				fd <= fid;
				repeat (3) step(1'b0, 1'b0, 12'h000);
				for (int l = 0; l < n_lines; l++) begin
					step(1'b0, 1'b1, 12'h000);
					for (int i = 0; i < n_pix; i++) begin
						step(1'b1, 1'b1, {3'b101, 4'(l), 5'(i)});
					end
					step(1'b0, 1'b1, 12'h000);
					// Field pin moves after line 0: only the rise edge counts
					if (l == 0) fd <= ~fid;
				end
				repeat (4) step(1'b0, 1'b0, 12'h000);
				ack <= req;
			end
		end
	end
endmodule

// File: testbench/video_capture_storage_tb_top.sv
// Purpose: Self-checking bench for the capture and storage block
// Assumes: Sensor model drives the raw pins on link_clk
// Notes: Limits shrunk to 16 by 8 so the bounds are reached quickly
`timescale 1ns/1ps
module video_capture_storage_tb_top;
	import vcs_pkg::*;
	localparam int HP = 16;
	localparam int VL = 8;
	localparam logic [31:0] TOP = 32'h0001_0000;
	localparam logic [31:0] IO = 32'h0000_0140;
	localparam logic [31:0] HO = 32'h0000_0110;
	localparam logic [31:0] HA = 32'h0002_0000;
	localparam logic [31:0] VA = 32'h0003_0000;
	logic core_clk = 1'b0;
	logic link_clk = 1'b0;
	logic sys_rst = 1'b1;
	vcs_cap_ctrl_s cap = '0;
	vcs_disp_ctrl_s disp = '0;
	vcs_region_s [3:0] region = '0;
	vcs_word_s yw = '0;
	logic hv, vv, fi, yr, mv, le, fe, take, ack;
	logic yv = 1'b0, mr = 1'b0, req = 1'b0, fid = 1'b0;
	logic tvs = 1'b0, tbl = 1'b0, tf = 1'b0, tal = 1'b0;
	logic [11:0] px;
	logic [11:0] thp = '0;
	logic [31:0] ma;
	logic [63:0] md;
	logic [7:0] tib = '0, tab = '0, tb;
	logic [4:0] npx = '0;
	logic [3:0] nln = '0;
	logic [2:0] inv = '0;
	logic [31:0] qa[$];
	logic [63:0] qd[$];
	int num_errors = 0, tests_run = 0, n_line = 0, n_frame = 0, cyc = 0;
	// --------
	// Clocks, instances and monitor
	// --------
	always #2 core_clk = ~core_clk;
	initial begin
		#0.7;
		forever #16 link_clk = ~link_clk;
	end
	vcs_top #(.MAX_HPIX(HP), .MAX_VLINE(VL)) vcs_top_inst (
		.core_clk(core_clk), .sys_rst(sys_rst), .link_clk(link_clk),
		.capture_channel_control(cap), .display_channel_control(disp),
		.anc_region(region), .top_start_addr(TOP), .hanc_start_addr(HA),
		.vanc_start_addr(VA), .image_line_offset_reg(IO),
		.hanc_line_offset(HO), .h_valid_in(hv), .v_valid_in(vv),
		.field_ident_in(fi), .raw_pixel_in(px), .yc_wr_valid(yv),
		.yc_wr_ready(yr), .yc_wr(yw), .mem_wr_valid(mv), .mem_wr_ready(mr),
		.mem_wr_addr(ma), .mem_wr_data(md), .line_event(le),
		.frame_event(fe), .tx_vsync_in(tvs), .tx_hpos(thp),
		.tx_in_hblank(tbl), .tx_field(tf), .tx_active_line(tal),
		.tx_image_byte(tib), .tx_anc_byte(tab), .tx_anc_take(take),
		.tx_byte(tb));
	vcs_sensor_model vcs_sensor_model_inst (.link_clk(link_clk),
		.req(req), .n_pix(npx), .n_lines(nln), .fid(fid), .inv(inv),
		.h_valid_in(hv), .v_valid_in(vv), .field_ident_in(fi),
		.raw_pixel_in(px), .ack(ack));
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (mv === 1'b1 && mr === 1'b1) begin
			qa.push_back(ma);
			qd.push_back(md);
		end
		if (le === 1'b1) n_line++;
		if (fe === 1'b1) n_frame++;
		if (cyc == 60000) begin
			num_errors++;
			report_and_stop();
		end
	end
	// Memory stalls every third cycle
	always @(negedge core_clk) mr <= (cyc % 3) != 0;
	// --------
	// Helpers
	// --------
	task automatic report_and_stop();
		if (num_errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [63:0] got,
		input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic vcs_cap_ctrl_s mk(input logic rm, il, fl,
		input logic [2:0] iv, input vcs_pix_e pw, input logic [10:0] lc);
		mk = '{capture_en: 1'b1, raw_mode: rm, interlaced: il,
			frame_layout: fl, hval_inv: iv[0], vval_inv: iv[1],
			fid_inv: iv[2], pix_width: pw, line_event_count: lc};
	endfunction
	task automatic frame(input int np, input int nl, input logic f);
		@(negedge core_clk);
		npx = 5'(np);
		nln = 4'(nl);
		fid = f;
		req = ~req;
		for (int k = 0; k < 20000 && req !== ack; k++) @(negedge core_clk);
		repeat (60) @(negedge core_clk);
	endtask
	// Two flush frames: new link-side settings land only at a vertical valid fall
	task automatic raw_run(input vcs_cap_ctrl_s c, input int np, nl,
		input logic f);
		@(negedge core_clk);
		cap = c;
		inv = {c.fid_inv, c.vval_inv, c.hval_inv};
		repeat (40) @(negedge core_clk);
		repeat (2) frame(np, nl, f);
		qa.delete();
		qd.delete();
		n_line = 0;
		n_frame = 0;
		frame(np, nl, f);
	endtask
	task automatic check_raw(input int np, nl, input vcs_pix_e pw,
		input logic [31:0] base, step);
		int s, nw, k, idx;
		logic [63:0] d;
		logic [11:0] p;
		s = (pw == VCS_PIX8) ? 8 : 4;
		nw = (np + s - 1) / s;
		check("raw words", 64'(qa.size()), 64'(nl * nw));
		for (int l = 0; l < nl; l++) begin
			for (int w = 0; w < nw; w++) begin
				d = '0;
				for (int j = 0; j < s; j++) begin
					idx = w * s + j;
					p = {3'b101, 4'(l), 5'(idx)};
					if (idx < np && s == 8) d[j*8+:8] = p[7:0];
					if (idx < np && s == 4) d[j*16+:16] = {4'h0, p} &
						((pw == VCS_PIX10) ? 16'h03FF : 16'h0FFF);
				end
				k = l * nw + w;
				if (k < qa.size()) begin
					check("raw addr", qa[k], 32'(base + l * step + w * 8));
					check("raw data", qd[k], d);
				end
			end
		end
	endtask
	task automatic yc_case(input vcs_kind_e k, input logic [2:0] ssf,
		input logic [31:0] ea);
		@(negedge core_clk);
		yv = 1'b1;
		yw = '{data: {32'hA5A5_0000, ea}, sof: ssf[2], sol: ssf[1],
			field: ssf[0], kind: k};
		#1;
		for (int t = 0; t < 50 && yr !== 1'b1; t++) begin
			@(negedge core_clk);
			#1;
		end
		@(posedge core_clk);
		@(negedge core_clk);
		yv = 1'b0;
		repeat (10) @(negedge core_clk);
		check("yc count", 64'(qa.size()), 64'd1);
		if (qa.size() > 0) begin
			check("yc addr", qa.pop_front(), ea);
			check("yc data", qd.pop_front(), {32'hA5A5_0000, ea});
		end
	endtask
	// --------
	// Scenarios
	// --------
	task automatic sc_raw8();
		raw_run(mk(1'b1, 1'b0, 1'b0, 3'b000, VCS_PIX8, 11'h001), 12, 3, 1'b0);
		check_raw(12, 3, VCS_PIX8, TOP, IO);
		check("line events", 64'(n_line), 64'd3);
		check("frame events", 64'(n_frame), 64'd1);
	endtask
	task automatic sc_raw10_inv();
		raw_run(mk(1'b1, 1'b1, 1'b1, 3'b111, VCS_PIX10, 11'h002), 6, 4, 1'b1);
		check_raw(6, 4, VCS_PIX10, TOP + IO, IO * 2);
		check("line events", 64'(n_line), 64'd2);
	endtask
	task automatic sc_raw12_field();
		raw_run(mk(1'b1, 1'b1, 1'b0, 3'b000, VCS_PIX12, 11'h000), 5, 2, 1'b1);
		check_raw(5, 2, VCS_PIX12, TOP, IO);
		check("line events", 64'(n_line), 64'd0);
	endtask
	task automatic sc_bounds();
		raw_run(mk(1'b1, 1'b0, 1'b0, 3'b000, VCS_PIX8, 11'h001), 20, 10, 1'b0);
		check_raw(HP, VL, VCS_PIX8, TOP, IO);
	endtask
	task automatic sc_yc();
		raw_run(mk(1'b0, 1'b1, 1'b1, 3'b000, VCS_PIX8, 11'h001), 4, 2, 1'b0);
		check("yc raw words", 64'(qa.size()), 64'd0);
		check("yc line events", 64'(n_line), 64'd0);
		yc_case(VCS_KIND_IMAGE, 3'b100, TOP);
		yc_case(VCS_KIND_IMAGE, 3'b000, TOP + 8);
		yc_case(VCS_KIND_IMAGE, 3'b010, TOP + IO * 2);
		yc_case(VCS_KIND_IMAGE, 3'b101, TOP + IO);
		yc_case(VCS_KIND_VANC, 3'b100, VA);
		yc_case(VCS_KIND_VANC, 3'b010, VA + IO * 2);
		yc_case(VCS_KIND_HANC, 3'b100, HA);
		yc_case(VCS_KIND_HANC, 3'b010, HA + HO * 2);
		raw_run(mk(1'b0, 1'b0, 1'b1, 3'b000, VCS_PIX8, 11'h001), 4, 2, 1'b0);
		yc_case(VCS_KIND_IMAGE, 3'b101, TOP);
	endtask
	task automatic sc_tx();
		logic inr;
		@(negedge core_clk);
		disp = '{display_en: 1'b1, anc_en: 1'b1};
		// start on a multiple of eight
		region[1] = '{hstart: 12'h008, hsize: 12'h004, vstart: 11'h000,
			vsize: 11'h004};
		repeat (40) @(negedge core_clk);
		@(negedge link_clk);
		tvs = 1'b1;
		@(negedge link_clk);
		tvs = 1'b0;
		for (int p = 0; p < 3; p++) begin
			for (int h = 0; h < 16; h++) begin
				@(negedge link_clk);
				thp = 12'(h);
				tf = (p == 2);
				tal = (p == 1);
				tbl = (p != 1);
				tib = 8'(8'h40 + h);
				tab = 8'(8'hA0 + h);
				inr = (p == 0) && h >= 8 && h < 12;
				#8;
				check("anc take", take, inr);
				@(posedge link_clk);
				#1;
				check("tx byte", tb, (p == 1) ? 8'(8'h40 + h) : inr ?
					8'(8'hA0 + h) : (h % 2) ? 8'h10 : 8'h80);
			end
		end
	endtask
	initial begin
		repeat (40) @(negedge core_clk);
		sys_rst = 1'b0;
		repeat (10) @(negedge core_clk);
		sc_raw8();
		sc_raw10_inv();
		sc_raw12_field();
		sc_bounds();
		sc_yc();
		sc_tx();
		report_and_stop();
	end
endmodule
